// >>> rtbp_params.svh
// Constants for the redundant trip bypass path
`ifndef RTBP_PARAMS_SVH
`define RTBP_PARAMS_SVH
`define RTBP_CLK_MHZ        100
`define RTBP_HB_TIMEOUT_US  1000
`define RTBP_HB_TIMEOUT_CYC (`RTBP_HB_TIMEOUT_US * `RTBP_CLK_MHZ)
`define RTBP_NUM_SENSORS    4
`define RTBP_NUM_ZONES      2
`define RTBP_FAULT_ACTIVE   1'b1
`endif

// >>> rtbp_pkg.sv
// Types for the redundant trip bypass path
`default_nettype none
package rtbp_pkg;
  // Firmware-side drive requests
  typedef struct packed {
    logic [1:0] coil;        // Pulsed coil drives
    logic [1:0] fault_out;   // Fault indicator outputs
    logic       fault_relay; // Fault indicator relay
    logic       brk_fail;    // Breaker failure output
    logic       err_relay;   // Unit error relay
    logic [3:0] lamps;       // Indicator lamps
  } rtbp_drv_t;
  // Synchronised field inputs
  typedef struct packed {
    logic [3:0] sensor;
    logic [1:0] trip;
    logic [1:0] inhibit;
    logic [1:0] fb;
    logic       rst_in;
    logic       rst_btn;
  } rtbp_in_t;
endpackage : rtbp_pkg
`default_nettype wire

// >>> rtbp_watchdog.sv
// Heartbeat watchdog that raises the bypass enable
`timescale 1ns/1ns
`default_nettype none
`include "rtbp_params.svh"
module rtbp_watchdog
  import rtbp_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `RTBP_HB_TIMEOUT_CYC
)(
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  input  wire logic hb_i,
  output logic      bypass_o
);
  // Watchdog state
  typedef struct packed {
    logic        hb_s1;
    logic        hb_s2;
    logic        hb_s3;
    logic [31:0] cnt;
    logic        byp;
  } rtbp_wd_t;
  rtbp_wd_t st_q, st_d;
  logic     hb_edge; // Heartbeat toggle seen
  // Next state
  always_comb
  begin
    st_d       = st_q;
    st_d.hb_s1 = hb_i;
    st_d.hb_s2 = st_q.hb_s1;
    st_d.hb_s3 = st_q.hb_s2;
    hb_edge    = st_q.hb_s2 ^ st_q.hb_s3;
    if (hb_edge)
    begin
      // Processor alive again
      st_d.cnt = 32'h0;
      st_d.byp = 1'b0;
    end
    else if (st_q.cnt >= TIMEOUT_CYC - 1)
    begin
      // Heartbeat missing too long
      st_d.byp = 1'b1;
    end
    else
    begin
      st_d.cnt = st_q.cnt + 32'h1;
    end
  end
  // State register
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  assign bypass_o = st_q.byp;
endmodule : rtbp_watchdog
`default_nettype wire

// >>> rtbp_top.sv
// Redundant trip bypass path: routing from trip inputs to outputs
// What this block does
// - Watchdog unblocks direct trip-to-output path.
// - Bypass ignores programmed delays entirely.
// - Bypass disables sensor presence and health.
// - Bypass ignores inhibit, feedback, resets; drives none.
// - Bypass disables fault relay and breaker-failure.
// - Lamps hold last state when processor stops.
// - Flashing lamp freezes fully on or off.
// - Bypass forces error relay to unit fault.
// - Trip input n drives coil n, output n.
// - Any light sensor trips both zones.
// - Firmware pulses actuator drives.
// - Bypass holds drives while light persists.
// - Only thermal protection drops held drive.
`timescale 1ns/1ns
`default_nettype none
`include "rtbp_params.svh"
module rtbp_top
  import rtbp_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `RTBP_HB_TIMEOUT_CYC
)(
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  input  wire logic       hb_i,           // Processor heartbeat toggle
  input  wire logic [3:0] sensor_i,       // Light over threshold
  input  wire logic [1:0] trip_i,         // External trip inputs
  input  wire logic [1:0] inhibit_i,      // Inhibit inputs
  input  wire logic       breaker_feedback_in_1_i,
  input  wire logic       breaker_feedback_in_2_i,
  input  wire logic       rst_in_i,       // Reset input
  input  wire logic       rst_btn_i,      // Reset button
  input  wire logic [1:0] overtemp_i,     // Switch too hot, per coil
  input  wire rtbp_drv_t  fw_i,           // Firmware drive requests
  input  wire logic [3:0] fw_sense_ok_i,  // Firmware sensor health
  output logic [1:0]      coil_o,         // Breaker actuator drives
  output logic            fault_indicator_out_1_o,
  output logic            fault_indicator_out_2_o,
  output logic            fault_indicator_relay_o,
  output logic            brk_fail_o,     // Breaker failure output
  output logic            err_relay_o,    // Unit error relay
  output logic [3:0]      lamps_o,        // Indicator lamps
  output logic [3:0]      sense_ok_o,     // Sensor health indication
  output logic            bypass_o        // Redundant path active
);
  // Whole block state
  typedef struct packed {
    rtbp_in_t  s1;
    rtbp_in_t  s2;
    logic [1:0] ot1;
    logic [1:0] ot2;
    logic [1:0] coil;
    logic [1:0] fout;
    logic       frelay;
    logic       bfail;
    logic       err;
    logic [3:0] lamps;
    logic [3:0] sok;
  } rtbp_st_t;
  rtbp_st_t  st_q, st_d;
  logic      byp;        // Bypass enable from watchdog
  logic      any_light;  // Any sensor sees light
  logic [1:0] zone_trip; // Per-zone trip in bypass

  // Heartbeat watchdog
  rtbp_watchdog #(
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) u_wd (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .hb_i     (hb_i),
    .bypass_o (byp)
  );

  // Next state
  always_comb
  begin
    st_d     = st_q;
    // Two-stage input synchronisers
    st_d.s1  = '{sensor: sensor_i, trip: trip_i, inhibit: inhibit_i,
                 fb: {breaker_feedback_in_2_i, breaker_feedback_in_1_i},
                 rst_in: rst_in_i, rst_btn: rst_btn_i};
    st_d.s2  = st_q.s1;
    st_d.ot1 = overtemp_i;
    st_d.ot2 = st_q.ot1;
    any_light = |st_q.s2.sensor;
    zone_trip = st_q.s2.trip | {2{any_light}};
    if (byp)
    begin
      // Direct routing, no timers involved
      st_d.coil   = zone_trip & ~st_q.ot2;
      st_d.fout   = zone_trip;
      // Feedback, inhibit and resets unread; relay and fail idle
      st_d.frelay = 1'b0;
      st_d.bfail  = 1'b0;
      st_d.err    = `RTBP_FAULT_ACTIVE;
      // Lamps frozen at last level, no blinking
      st_d.lamps  = st_q.lamps;
      st_d.sok    = 4'h0;
    end
    else
    begin
      // Firmware owns every output but bypass_o, coils pulsed by it and cut by overtemp
      st_d.coil   = fw_i.coil & ~st_q.ot2;
      st_d.fout   = fw_i.fault_out;
      st_d.frelay = fw_i.fault_relay;
      st_d.bfail  = fw_i.brk_fail;
      st_d.err    = fw_i.err_relay;
      st_d.lamps  = fw_i.lamps;
      st_d.sok    = fw_sense_ok_i;
    end
  end

  // State register
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // Outputs from flip-flops
  assign coil_o                  = st_q.coil;
  assign fault_indicator_out_1_o = st_q.fout[0];
  assign fault_indicator_out_2_o = st_q.fout[1];
  assign fault_indicator_relay_o = st_q.frelay;
  assign brk_fail_o              = st_q.bfail;
  assign err_relay_o             = st_q.err;
  assign lamps_o                 = st_q.lamps;
  assign sense_ok_o              = st_q.sok;
  assign bypass_o                = byp;
endmodule : rtbp_top
`default_nettype wire

// >>> rtbp_top_monitor.sv
// Bypass path checker
`timescale 1ns/1ns
`default_nettype none
module rtbp_top_monitor #(parameter int unsigned TIMEOUT_CYC = 20)(
  input wire logic       mclk_i,
  input wire logic       resetn_i,
  input wire logic       hb_i,
  input wire logic [3:0] sensor_i,
  input wire logic [1:0] trip_i,
  input wire logic [1:0] overtemp_i,
  input wire logic [1:0] coil_o,
  input wire logic       fault_indicator_out_1_o,
  input wire logic       fault_indicator_relay_o,
  input wire logic       brk_fail_o,
  input wire logic       err_relay_o,
  input wire logic [3:0] lamps_o,
  input wire logic [3:0] sense_ok_o,
  input wire logic       bypass_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  logic [31:0] idle_q;  // Cycles since last heartbeat edge
  logic        hb_q;
  // Heartbeat silence counter
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      // Silence count restarts with reset
      hb_q   <= 1'b0;
      idle_q <= 32'h0;
    end
    else
    begin
      // Any heartbeat change restarts the count
      hb_q   <= hb_i;
      idle_q <= (hb_i != hb_q) ? 32'h0 : idle_q + 32'h1;
    end
  end
  err_forced_a: assert property ($past(bypass_o) |-> err_relay_o) else $error("err relay");
  relays_idle_a: assert property ($past(bypass_o) |-> !fault_indicator_relay_o && !brk_fail_o)
    else $error("relay driven");
  health_off_a: assert property ($past(bypass_o) |-> sense_ok_o == 4'h0) else $error("health");
  lamps_hold_a: assert property ($past(bypass_o, 2) && $past(bypass_o) |-> $stable(lamps_o))
    else $error("lamps");
  light_both_a: assert property ((bypass_o && |sensor_i && overtemp_i == 2'h0)[*3] |=> coil_o == 2'h3)
    else $error("light trip");
  trip_one_a: assert property ((bypass_o && trip_i == 2'h1 && sensor_i == 4'h0)[*3] |=> fault_indicator_out_1_o)
    else $error("trip route");
  heat_drop_a: assert property (overtemp_i[0][*3] |=> !coil_o[0]) else $error("overtemp");
  wdog_early_a: assert property ($rose(bypass_o) |-> idle_q >= TIMEOUT_CYC) else $error("early");
  wdog_late_a: assert property (idle_q == TIMEOUT_CYC + 12 |-> bypass_o) else $error("late");
  cover property ($rose(bypass_o));
  cover property (bypass_o && coil_o == 2'h3);
  cover property (bypass_o && overtemp_i[0] && |sensor_i);
endmodule : rtbp_top_monitor
`default_nettype wire

// >>> rtbp_field.sv
// Field side: light sensors and external trip contacts
`timescale 1ns/1ns
`default_nettype none
module rtbp_field (
  input  wire logic [3:0] light_i,
  input  wire logic [1:0] close_i,
  output logic [3:0]      sensor_o,
  output logic [1:0]      trip_o
);
  // Contacts are wired straight to the pins
  assign sensor_o = light_i;
  assign trip_o   = close_i;
endmodule : rtbp_field
`default_nettype wire

// >>> test_rtbp_top.sv
// Testbench for the redundant trip bypass path
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; $display("Error %s exp %h got %h", n, e, g); end end
module test_rtbp_top
  import rtbp_pkg::*;
;
  localparam int TO = 20;
  logic mclk_i = 1'h0, resetn_i = 1'h0, hb_i = 1'h0, hb_run = 1'h0, f1 = 1'h0, f2 = 1'h0, ri = 1'h0, rb = 1'h0;
  logic [1:0] trip_q = 2'h0, inh = 2'h0, ot = 2'h0, fo, coil_o, tr;
  logic [3:0] light_q = 4'h0, sok = 4'h0, sn, lamps_o, sense_ok_o, lm;
  logic o1, o2, frel, bf, err, byp;
  logic [10:0] fwx; // Expected firmware-mode outputs
  rtbp_drv_t fw = '0;
  int fail_count = 0, checked = 0, s;
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (hb_run) hb_i <= ~hb_i;
  rtbp_field i_rtbp_field (.light_i(light_q), .close_i(trip_q), .sensor_o(sn), .trip_o(tr));
  rtbp_top #(.TIMEOUT_CYC(TO)) i_rtbp_top (.mclk_i(mclk_i), .resetn_i(resetn_i), .hb_i(hb_i), .sensor_i(sn),
    .trip_i(tr), .inhibit_i(inh), .breaker_feedback_in_1_i(f1), .breaker_feedback_in_2_i(f2), .rst_in_i(ri),
    .rst_btn_i(rb), .overtemp_i(ot), .fw_i(fw), .fw_sense_ok_i(sok), .coil_o(coil_o),
    .fault_indicator_out_1_o(o1), .fault_indicator_out_2_o(o2), .fault_indicator_relay_o(frel),
    .brk_fail_o(bf), .err_relay_o(err), .lamps_o(lamps_o), .sense_ok_o(sense_ok_o), .bypass_o(byp));
  // Closing verdict
  task end_of_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    #100000 fail_count++;
    end_of_test();
  end
  // Main sequence
  initial
  begin
    s = $urandom(43757);
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'h1;
    hb_run <= 1'h1;
    fw <= 11'($urandom);
    sok <= 4'($urandom);
    repeat (6) @(posedge mclk_i);
    lm = fw.lamps;
    fwx = {fw.coil, fw.fault_out, fw.fault_relay, fw.brk_fail, fw.err_relay, sok};
    `CHK("byp", 1'b0, byp)
    `CHK("lamps", lm, lamps_o)
    `CHK("firmware", fwx, {coil_o, o2, o1, frel, bf, err, sense_ok_o})
    $display("firmware mode done");
    hb_run <= 1'h0;
    repeat (TO + 16) @(posedge mclk_i);
    fw <= '1;
    sok <= 4'hf;
    `CHK("byp", 1'b1, byp)
    repeat (40)
    begin
      light_q <= ($urandom % 3 == 0) ? 4'($urandom) : 4'h0;
      {trip_q, ot, inh, f1, f2, ri, rb} <= 10'($urandom);
      repeat (5) @(posedge mclk_i);
      fo = {2{|light_q}} | trip_q;
      `CHK("coil", fo & ~ot, coil_o)
      `CHK("outs", fo, {o2, o1})
      `CHK("err", 1'b1, err)
      `CHK("relays", 2'h0, {frel, bf})
      `CHK("health", 4'h0, sense_ok_o)
      `CHK("lamps", lm, lamps_o)
    end
    $display("bypass routing done");
    hb_run <= 1'h1;
    repeat (8) @(posedge mclk_i);
    `CHK("byp", 1'b0, byp)
    $display("recovery done");
    resetn_i <= 1'h0;
    @(negedge mclk_i);
    `CHK("reset", 16'h0, {coil_o, o1, o2, frel, bf, err, lamps_o, sense_ok_o, byp})
    @(posedge mclk_i);
    resetn_i <= 1'h1;
    repeat (4) @(posedge mclk_i);
    `CHK("byp", 1'b0, byp)
    $display("reset done");
    end_of_test();
  end
endmodule : test_rtbp_top
bind rtbp_top rtbp_top_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_rtbp_top_monitor (.mclk_i(mclk_i), .resetn_i(resetn_i),
  .hb_i(hb_i), .sensor_i(sensor_i), .trip_i(trip_i), .overtemp_i(overtemp_i), .coil_o(coil_o),
  .fault_indicator_out_1_o(fault_indicator_out_1_o), .fault_indicator_relay_o(fault_indicator_relay_o),
  .brk_fail_o(brk_fail_o), .err_relay_o(err_relay_o), .lamps_o(lamps_o), .sense_ok_o(sense_ok_o), .bypass_o(bypass_o));
`default_nettype wire
